// file: pkg/stscr_pkg.sv
// stscr_pkg: offsets, field positions and reset values of the
// transmit/sync configuration register bank.
// assumes: an 8-bit register port with a 3-bit word address.
package stscr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] STSCR_OFF_TX_CTL  = 3'h0;
  localparam logic [2:0] STSCR_OFF_SYNC_LO = 3'h1;
  localparam logic [2:0] STSCR_OFF_SYNC_HI = 3'h2;
  localparam logic [2:0] STSCR_OFF_EXT     = 3'h3;
  localparam logic [2:0] STSCR_OFF_STATUS  = 3'h4;

  // ----------------------------------------------------------------
  // transmit control fields
  // ----------------------------------------------------------------
  localparam int STSCR_TX_DTR     = 7;
  localparam int STSCR_TX_LEN_HI  = 6;
  localparam int STSCR_TX_LEN_LO  = 5;
  localparam int STSCR_TX_BREAK   = 4;
  localparam int STSCR_TX_ENABLE  = 3;
  localparam int STSCR_TX_CRC16   = 2;
  localparam int STSCR_TX_RTS     = 1;
  localparam int STSCR_TX_CRC_EN  = 0;

  localparam logic [1:0] STSCR_LEN_5 = 2'h0;
  localparam logic [1:0] STSCR_LEN_7 = 2'h1;
  localparam logic [1:0] STSCR_LEN_6 = 2'h2;
  localparam logic [1:0] STSCR_LEN_8 = 2'h3;

  // ----------------------------------------------------------------
  // extended option fields
  // ----------------------------------------------------------------
  localparam int STSCR_EXT_MBZ       = 7;
  localparam int STSCR_EXT_RD_EN     = 6;
  localparam int STSCR_EXT_TXF_LVL   = 5;
  localparam int STSCR_EXT_REQ_TIME  = 4;
  localparam int STSCR_EXT_RXF_LVL   = 3;
  localparam int STSCR_EXT_AUTO_RTS  = 2;
  localparam int STSCR_EXT_AUTO_EOM  = 1;
  localparam int STSCR_EXT_AUTO_FLAG = 0;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] STSCR_RST_TX_CTL = 8'h00;
  localparam logic [7:0] STSCR_RST_SYNC   = 8'h00;
  localparam logic [7:0] STSCR_RST_EXT    = 8'h20;
  localparam logic [7:0] STSCR_SDLC_FLAG  = 8'h7e;
  localparam logic [7:0] STSCR_MASK_ALL   = 8'hff;
  localparam logic [7:0] STSCR_MASK_RANGE = 8'hf0;
  localparam logic [3:0] STSCR_NIB_ONES   = 4'hf;

  // ----------------------------------------------------------------
  // sync mode selection from the mode register
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STSCR_MODE_SYNC8  = 2'b00,
    STSCR_MODE_SYNC16 = 2'b01,
    STSCR_MODE_SDLC   = 2'b10,
    STSCR_MODE_EXT    = 2'b11
  } stscr_mode_t;

endpackage : stscr_pkg

// file: verilog/stscr_regs.sv
// stscr_regs: write-only transmit, sync and extended option registers
// of one serial channel, with decoded and effective outputs.
// assumes: host port synchronous to mclk; sync mode, 12-bit bisync and
// address range selection come from the mode registers elsewhere.
// Summary of operation
// - tx length bits 6:5 code 5,7,6,8 bits; bit 2 picks crc-16 else ccitt
// - low sync holds sync byte or address; 12-bit bisync low nibble ones
// - high sync holds upper sync bits; sdlc forces flag pattern 01111110
// - extended options reset to 0x20; bit 7 always held zero
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module stscr_regs
  import stscr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rd_data,
  input  wire logic [1:0]  sync_mode,
  input  wire logic        bisync_12,
  input  wire logic        addr_range,
  output logic             dtr,
  output logic      [3:0]  tx_char_bits,
  output logic             send_break,
  output logic             tx_enable,
  output logic             crc16_sel,
  output logic             rts,
  output logic             tx_crc_enable,
  output logic      [7:0]  sync_low,
  output logic      [7:0]  sync_high,
  output logic      [7:0]  addr_cmp_mask,
  output logic      [7:0]  ext_options
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tx_ctl;
    logic [3:0] char_bits;
    logic [7:0] sync_lo;
    logic [7:0] sync_hi;
    logic [7:0] sync_lo_eff;
    logic [7:0] sync_hi_eff;
    logic [7:0] mask;
    logic [7:0] ext;
    logic [7:0] rdata;
  } stscr_state_t;

  stscr_state_t st_reg;
  stscr_state_t st_next;
  logic         sdlc_mode;
  logic         bisync_12_mode;

  assign sdlc_mode      = (sync_mode == STSCR_MODE_SDLC);
  assign bisync_12_mode = (sync_mode == STSCR_MODE_SYNC16) && bisync_12;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 8'h00;
    if (wr_stb) begin
      case (addr)
        STSCR_OFF_TX_CTL:  st_next.tx_ctl  = wr_data;
        STSCR_OFF_SYNC_LO: st_next.sync_lo = wr_data;
        STSCR_OFF_SYNC_HI: st_next.sync_hi = wr_data;
        STSCR_OFF_EXT: begin
          st_next.ext                = wr_data;
          st_next.ext[STSCR_EXT_MBZ] = 1'b0;
        end
        default: ;
      endcase
    end
    case (st_next.tx_ctl[STSCR_TX_LEN_HI:STSCR_TX_LEN_LO])
      STSCR_LEN_5: st_next.char_bits = 4'h5;
      STSCR_LEN_7: st_next.char_bits = 4'h7;
      STSCR_LEN_6: st_next.char_bits = 4'h6;
      default:     st_next.char_bits = 4'h8;
    endcase
    st_next.sync_lo_eff = st_next.sync_lo;
    if (bisync_12_mode) begin
      st_next.sync_lo_eff[3:0] = STSCR_NIB_ONES;
    end
    st_next.mask = (sdlc_mode && addr_range) ? STSCR_MASK_RANGE
                                             : STSCR_MASK_ALL;
    st_next.sync_hi_eff = sdlc_mode ? STSCR_SDLC_FLAG
                                    : st_next.sync_hi;
    if (rd_stb) begin
      case (addr)
        STSCR_OFF_STATUS: st_next.rdata = {st_reg.tx_ctl[STSCR_TX_ENABLE],
                                           st_reg.tx_ctl[STSCR_TX_CRC16],
                                           sdlc_mode, bisync_12_mode,
                                           st_reg.char_bits};
        default:          st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg.tx_ctl      <= STSCR_RST_TX_CTL;
      st_reg.char_bits   <= 4'h5;
      st_reg.sync_lo     <= STSCR_RST_SYNC;
      st_reg.sync_hi     <= STSCR_RST_SYNC;
      st_reg.sync_lo_eff <= STSCR_RST_SYNC;
      st_reg.sync_hi_eff <= STSCR_RST_SYNC;
      st_reg.mask        <= STSCR_MASK_ALL;
      st_reg.ext         <= STSCR_RST_EXT;
      st_reg.rdata       <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data       = st_reg.rdata;
  assign dtr           = st_reg.tx_ctl[STSCR_TX_DTR];
  assign tx_char_bits  = st_reg.char_bits;
  assign send_break    = st_reg.tx_ctl[STSCR_TX_BREAK];
  assign tx_enable     = st_reg.tx_ctl[STSCR_TX_ENABLE];
  assign crc16_sel     = st_reg.tx_ctl[STSCR_TX_CRC16];
  assign rts           = st_reg.tx_ctl[STSCR_TX_RTS];
  assign tx_crc_enable = st_reg.tx_ctl[STSCR_TX_CRC_EN];
  assign sync_low      = st_reg.sync_lo_eff;
  assign sync_high     = st_reg.sync_hi_eff;
  assign addr_cmp_mask = st_reg.mask;
  assign ext_options   = st_reg.ext;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tx_char_len: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_TX_CTL && wr_data[6:5] == 2'b01)
      |=> (tx_char_bits == 4'h7) && (crc16_sel == $past(wr_data[2])))
    else $error("tx length or crc select wrong after write");

  a_bisync_low_ones: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sync_mode == 2'b01 && bisync_12) |=> (sync_low[3:0] == 4'hf))
    else $error("low sync nibble not ones in 12-bit bisync");

  a_sdlc_flag_out: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sync_mode == 2'b10) ##1 (sync_mode == 2'b10)
      |=> (sync_high == 8'h7e) && $stable(sync_high))
    else $error("sdlc flag pattern not presented");

  a_ext_bit_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_EXT)
      |=> (ext_options == {1'b0, $past(wr_data[6:0])}))
    else $error("extended options not stored with bit 7 zero");

  a_tx_len_codes: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_TX_CTL)
      |=> (tx_char_bits == (($past(wr_data[6:5]) == STSCR_LEN_5) ? 4'h5 :
                            ($past(wr_data[6:5]) == STSCR_LEN_7) ? 4'h7 :
                            ($past(wr_data[6:5]) == STSCR_LEN_6) ? 4'h6 :
                                                                   4'h8)))
    else $error("tx character length not decoded from write");

  a_tx_bits_stored: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_TX_CTL)
      |=> ({dtr, send_break, tx_enable, crc16_sel, rts, tx_crc_enable} ==
           {$past(wr_data[7]), $past(wr_data[4:0])}))
    else $error("tx control bits not stored from write");

  a_low_byte_held: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_SYNC_LO &&
     !(sync_mode == STSCR_MODE_SYNC16 && bisync_12))
      |=> (sync_low == $past(wr_data)))
    else $error("low sync byte not stored from write");

  a_range_mask: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sync_mode == STSCR_MODE_SDLC && addr_range)
      |=> (addr_cmp_mask == STSCR_MASK_RANGE))
    else $error("address range mask not applied");

  a_full_mask: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(sync_mode == STSCR_MODE_SDLC && addr_range)
      |=> (addr_cmp_mask == STSCR_MASK_ALL))
    else $error("full address mask not applied");

  a_high_byte_held: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_stb && addr == STSCR_OFF_SYNC_HI && sync_mode != STSCR_MODE_SDLC)
      |=> (sync_high == $past(wr_data)))
    else $error("high sync byte not stored from write");

  a_ext_reset_val: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(nrst) |-> (ext_options == STSCR_RST_EXT) &&
                    (tx_char_bits == 4'h5) && (rd_data == 8'h00))
    else $error("registers not at reset values after reset");

  a_ext_mbz_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    (ext_options[STSCR_EXT_MBZ] == 1'b0))
    else $error("extended option bit 7 not zero");

  a_ext_held: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(wr_stb && addr == STSCR_OFF_EXT) |=> $stable(ext_options))
    else $error("extended options changed without a write");

  a_rd_status_word: assert property (
    @(posedge mclk) disable iff (!nrst)
    (rd_stb && addr == STSCR_OFF_STATUS)
      |=> (rd_data == {$past(tx_enable), $past(crc16_sel),
                       $past(sync_mode == STSCR_MODE_SDLC),
                       $past(sync_mode == STSCR_MODE_SYNC16 && bisync_12),
                       $past(tx_char_bits)}))
    else $error("status read word wrong");

  a_rd_idle_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    !rd_stb |=> (rd_data == 8'h00))
    else $error("read data not zero outside a read");

endmodule : stscr_regs

// file: sim/stscr_mode_model.sv
// stscr_mode_model: stands in for the mode registers that pick sync mode.
// assumes: requests from the bench, outputs registered on mclk.
`timescale 1ns/1ps
module stscr_mode_model
  import stscr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [1:0] mode_req,
  input  wire logic       b12_req,
  input  wire logic       rng_req,
  output logic      [1:0] sync_mode,
  output logic            bisync_12,
  output logic            addr_range
);
  // ----------------------------------------------------------------
  // mode register copy, cleared by reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_mode  <= STSCR_MODE_SYNC8;
      bisync_12  <= 1'b0;
      addr_range <= 1'b0;
    end else begin
      sync_mode  <= mode_req;
      bisync_12  <= b12_req;
      addr_range <= rng_req;
    end
  end
endmodule : stscr_mode_model

// file: sim/testbench.sv
// testbench: register port tests of the transmit/sync register bank.
// assumes: stscr_regs and stscr_mode_model, one 10 MHz clock.
`timescale 1ns/1ps
module testbench;
  import stscr_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00, rd_data, sync_low, sync_high, mask, ext;
  logic [1:0] mode_req = 2'h0, sync_mode;
  logic b12_req = 1'b0, rng_req = 1'b0, bisync_12, addr_range;
  logic dtr, send_break, tx_enable, crc16_sel, rts, tx_crc_enable;
  logic [3:0] tx_char_bits;
  logic [7:0] tx_bits;
  assign tx_bits = {dtr, 2'h0, send_break, tx_enable,
                    crc16_sel, rts, tx_crc_enable};
  int fail_count = 0, cmp_count = 0;
  logic [3:0] len_tab [4] = '{4'h5, 4'h7, 4'h6, 4'h8};
  stscr_mode_model i_stscr_mode_model (.mclk(mclk), .nrst(nrst),
    .mode_req(mode_req), .b12_req(b12_req), .rng_req(rng_req),
    .sync_mode(sync_mode), .bisync_12(bisync_12), .addr_range(addr_range));
  stscr_regs i_stscr_regs (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .sync_mode(sync_mode), .bisync_12(bisync_12), .addr_range(addr_range),
    .dtr(dtr), .tx_char_bits(tx_char_bits), .send_break(send_break),
    .tx_enable(tx_enable), .crc16_sel(crc16_sel), .rts(rts),
    .tx_crc_enable(tx_crc_enable), .sync_low(sync_low),
    .sync_high(sync_high), .addr_cmp_mask(mask), .ext_options(ext));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wr_data <= d; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic mode(input logic [1:0] m, input logic b, input logic r);
    @(posedge mclk);
    mode_req <= m; b12_req <= b; rng_req <= r;
    repeat (3) @(posedge mclk);
    #1;
  endtask : mode
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    #200000 fail_count++;
    finish_test();
  end
  initial begin
    logic [7:0] d, t;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1 chk(ext, STSCR_RST_EXT);
    chk({4'h0, tx_char_bits}, 8'h05);
    chk(tx_bits, 8'h00);
    chk(sync_low, 8'h00);
    chk(mask, STSCR_MASK_ALL);
    chk(sync_high, 8'h00);
    rd(STSCR_OFF_STATUS, d);
    chk(d, 8'h05);
    $display("test reset done");
    wr(STSCR_OFF_SYNC_LO, 8'h00);
    wr(STSCR_OFF_SYNC_HI, 8'h00);
    for (int i = 0; i < 4; i++) begin
      t = {1'(i), 2'(i), 1'(i >> 1), 1'b1, 1'(i), 2'(i)};
      wr(STSCR_OFF_TX_CTL, t);
      chk(tx_bits, t & 8'h9f);
      chk({4'h0, tx_char_bits}, {4'h0, len_tab[i]});
      chk({7'h0, crc16_sel}, {7'h0, 1'(i)});
      rd(STSCR_OFF_STATUS, d);
      chk(d, {1'b1, 1'(i), 2'b00, len_tab[i]});
    end
    rd(STSCR_OFF_TX_CTL, d);
    chk(d, 8'h00);
    $display("test tx control done");
    wr(STSCR_OFF_SYNC_LO, 8'h5a);
    chk(sync_low, 8'h5a);
    mode(STSCR_MODE_SYNC16, 1'b1, 1'b0);
    chk(sync_low, 8'h5f);
    rd(STSCR_OFF_STATUS, d);
    chk(d, 8'hd8);
    mode(STSCR_MODE_SDLC, 1'b0, 1'b1);
    chk(sync_low, 8'h5a);
    chk(mask, STSCR_MASK_RANGE);
    $display("test sync low done");
    wr(STSCR_OFF_SYNC_HI, 8'h33);
    chk(sync_high, STSCR_SDLC_FLAG);
    mode(STSCR_MODE_SYNC16, 1'b0, 1'b0);
    chk(sync_high, 8'h33);
    chk(mask, STSCR_MASK_ALL);
    mode(STSCR_MODE_SDLC, 1'b1, 1'b0);
    chk(sync_low, 8'h5a);
    chk(mask, STSCR_MASK_ALL);
    chk(sync_high, STSCR_SDLC_FLAG);
    rd(STSCR_OFF_STATUS, d);
    chk(d, 8'he8);
    mode(STSCR_MODE_EXT, 1'b0, 1'b1);
    chk(sync_high, 8'h33);
    chk(mask, STSCR_MASK_ALL);
    rd(STSCR_OFF_STATUS, d);
    chk(d, 8'hc8);
    $display("test sync high done");
    wr(STSCR_OFF_EXT, 8'hff);
    chk(ext, 8'h7f);
    wr(3'h5, 8'h00);
    chk(ext, 8'h7f);
    wr(STSCR_OFF_EXT, 8'h00);
    chk(ext, 8'h00);
    $display("test extended options done");
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1 chk(ext, STSCR_RST_EXT);
    chk({4'h0, tx_char_bits}, 8'h05);
    chk(tx_bits, 8'h00);
    chk(sync_high, 8'h00);
    $display("test second reset done");
    finish_test();
  end
endmodule : testbench
